// *** fac_pkg.sv ***
// Shared constants and types for the FIR output accumulate and combine stage
package fac_pkg;

  // ********************************************
  // Widths
  // ********************************************
  localparam int DATA_W = 10;
  localparam int PROD_W = 22;
  localparam int RES_W = 28;
  localparam int TAPS = 4;
  localparam int CELLS = 2;
  localparam int CFG_ADDR_W = 9;
  localparam int CFG_W = 10;

  // ********************************************
  // Configuration register map
  // ********************************************
  localparam logic [CFG_ADDR_W-1:0] ADDR_CFG_MAIN = 9'h000;
  localparam logic [CFG_ADDR_W-1:0] ADDR_CFG_AUX = 9'h001;
  localparam logic [CFG_W-1:0] CFG_MAIN_RESET = 10'h000;
  localparam logic [CFG_W-1:0] CFG_AUX_RESET = 10'h010;

  // Fields of filter_config_main
  localparam int MAIN_DECIM_LSB = 0;
  localparam int MAIN_DECIM_W = 4;
  localparam int MAIN_ODD_SYM_BIT = 5;

  // Fields of filter_config_aux
  localparam int AUX_ROUND_LSB = 0;
  localparam int AUX_ROUND_W = 4;
  localparam int AUX_REV_DIS_BIT = 4;
  localparam int AUX_ROUND_EN_BIT = 5;
  localparam int AUX_DATA_TC_BIT = 6;
  localparam int AUX_COEF_TC_BIT = 7;

  // ********************************************
  // Arithmetic constants
  // ********************************************
  // Result bit carrying weight 2^-10, the lowest round position
  localparam int ROUND_BASE_BIT = 8;
  localparam logic [AUX_ROUND_W-1:0] ROUND_POS_MAX = 4'hb;
  localparam int SCALE_SHIFT = 10;

  // ********************************************
  // Output select codes
  // ********************************************
  typedef enum logic [1:0] {
    FAC_SEL_SCALED_SUM = 2'h0,
    FAC_SEL_SUM = 2'h1,
    FAC_SEL_CELL_A = 2'h2,
    FAC_SEL_CELL_B = 2'h3
  } fac_sel_t;

endpackage : fac_pkg

// *** fac_accum_cell.sv ***
// One FIR cell accumulator with its output holding register
`timescale 1ns/1ps
module fac_accum_cell (
  input wire logic clock,
  input wire logic reset,
  input wire logic accumulate_enable,
  input wire logic product_signed,
  input wire logic [fac_pkg::TAPS-1:0][fac_pkg::PROD_W-1:0] products,
  output logic [fac_pkg::RES_W-1:0] hold
);
  import fac_pkg::*;

  // ********************************************
  // Product widening and summing
  // ********************************************
  logic [RES_W-1:0] acc;
  logic [TAPS-1:0][RES_W-1:0] widened;
  logic [RES_W-1:0] product_sum;
  logic [RES_W-1:0] feedback;
  logic [RES_W-1:0] next_acc;

  genvar t;
  generate
    for (t = 0; t < TAPS; t++) begin : g_widen
      assign widened[t] = {{(RES_W-PROD_W){product_signed & products[t][PROD_W-1]}}, products[t]};
    end
  endgenerate

  always_comb begin
    product_sum = '0;
    for (int i = 0; i < TAPS; i++) begin
      product_sum = product_sum + widened[i];
    end
  end

  assign feedback = accumulate_enable ? acc : '0;
  assign next_acc = feedback + product_sum;

  // ********************************************
  // Accumulator and holding register
  // ********************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hold <= '0;
    end else if (!accumulate_enable) begin
      hold <= acc;
    end
  end

endmodule : fac_accum_cell

// *** fac_output_stage.sv ***
// Output stage of the dual FIR: two cell accumulators, mux/adder, rounding, configuration
`timescale 1ns/1ps
module fac_output_stage (
  input wire logic clock,
  input wire logic reset,
  input wire logic accumulate_enable,
  input wire logic [1:0] output_select,
  input wire logic [fac_pkg::TAPS-1:0][fac_pkg::PROD_W-1:0] product_a,
  input wire logic [fac_pkg::TAPS-1:0][fac_pkg::PROD_W-1:0] product_b,
  input wire logic [fac_pkg::CFG_ADDR_W-1:0] cfg_address,
  input wire logic [fac_pkg::CFG_W-1:0] cfg_data,
  input wire logic cfg_write_n,
  output logic [fac_pkg::RES_W-1:0] result_bus,
  output logic result_valid,
  output logic result_is_unsigned,
  output logic [fac_pkg::MAIN_DECIM_W-1:0] decimation_factor,
  output logic odd_symmetry,
  output logic reversal_disable
);
  import fac_pkg::*;

  // ********************************************
  // Helper functions
  // ********************************************
  // One at result bit ROUND_BASE_BIT + pos; positions past the top are clamped
  function automatic logic [RES_W-1:0] round_mask(input logic [AUX_ROUND_W-1:0] pos);
    logic [AUX_ROUND_W-1:0] p;
    logic [RES_W-1:0] one;
    p = (pos > ROUND_POS_MAX) ? ROUND_POS_MAX : pos;
    one = {{(RES_W-1){1'b0}}, 1'b1};
    return one << (ROUND_BASE_BIT + int'(p));
  endfunction : round_mask

  // Divide by 2^SCALE_SHIFT, keeping the sign when the format is signed
  function automatic logic [RES_W-1:0] scale_down(input logic [RES_W-1:0] v, input logic signed_fmt);
    logic [SCALE_SHIFT-1:0] fill;
    fill = {SCALE_SHIFT{signed_fmt & v[RES_W-1]}};
    return {fill, v[RES_W-1:SCALE_SHIFT]};
  endfunction : scale_down

  // ********************************************
  // Configuration registers
  // ********************************************
  logic [CFG_W-1:0] cfg_main;
  logic [CFG_W-1:0] cfg_aux;
  logic hit_main;
  logic hit_aux;

  assign hit_main = !cfg_write_n && (cfg_address == ADDR_CFG_MAIN);
  assign hit_aux = !cfg_write_n && (cfg_address == ADDR_CFG_AUX);

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_main <= CFG_MAIN_RESET;
    end else if (hit_main) begin
      cfg_main <= cfg_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_aux <= CFG_AUX_RESET;
    end else if (hit_aux) begin
      cfg_aux <= cfg_data;
    end
  end

  // ********************************************
  // Configuration decode
  // ********************************************
  logic cfg_odd_sym;
  logic cfg_data_tc;
  logic cfg_coef_tc;
  logic cfg_round_en;
  logic [AUX_ROUND_W-1:0] cfg_round_pos;
  logic fmt_unsigned;
  logic fmt_signed;

  assign cfg_odd_sym = cfg_main[MAIN_ODD_SYM_BIT];
  assign cfg_data_tc = cfg_aux[AUX_DATA_TC_BIT];
  assign cfg_coef_tc = cfg_aux[AUX_COEF_TC_BIT];
  assign cfg_round_en = cfg_aux[AUX_ROUND_EN_BIT];
  assign cfg_round_pos = cfg_aux[AUX_ROUND_LSB +: AUX_ROUND_W];
  assign fmt_unsigned = !cfg_odd_sym && !cfg_data_tc && !cfg_coef_tc;
  assign fmt_signed = !fmt_unsigned;

  // ********************************************
  // Cell accumulators
  // ********************************************
  logic [CELLS-1:0][TAPS-1:0][PROD_W-1:0] products;
  logic [CELLS-1:0][RES_W-1:0] holds;

  assign products[0] = product_a;
  assign products[1] = product_b;

  genvar c;
  generate
    for (c = 0; c < CELLS; c++) begin : g_cell
      fac_accum_cell u_cell (
        .clock(clock),
        .reset(reset),
        .accumulate_enable(accumulate_enable),
        .product_signed(fmt_signed),
        .products(products[c]),
        .hold(holds[c])
      );
    end
  endgenerate

  // ********************************************
  // Mux/adder and rounding
  // ********************************************
  logic [RES_W-1:0] cell_a_result;
  logic [RES_W-1:0] cell_b_result;
  logic [RES_W-1:0] cell_b_scaled;
  logic [RES_W-1:0] sum_scaled;
  logic [RES_W-1:0] sum_plain;
  logic [RES_W-1:0] selected;
  logic [RES_W-1:0] round_term;
  logic [RES_W-1:0] next_result;

  assign cell_a_result = holds[0];
  assign cell_b_result = holds[1];
  assign cell_b_scaled = scale_down(cell_b_result, fmt_signed);
  assign sum_scaled = cell_a_result + cell_b_scaled;
  assign sum_plain = cell_a_result + cell_b_result;
  assign round_term = cfg_round_en ? round_mask(cfg_round_pos) : '0;
  // Same bit weights for both formats; only the meaning of bit 27 differs
  assign next_result = selected + round_term;

  always_comb begin
    unique case (fac_sel_t'(output_select))
      FAC_SEL_SCALED_SUM: selected = sum_scaled;
      FAC_SEL_SUM: selected = sum_plain;
      FAC_SEL_CELL_A: selected = cell_a_result;
      FAC_SEL_CELL_B: selected = cell_b_result;
    endcase
  end

  // ********************************************
  // Registered outputs
  // ********************************************
  logic hold_loaded;

  always_ff @(posedge clock) begin
    if (reset) begin
      result_bus <= '0;
    end else begin
      result_bus <= next_result;
    end
  end

  // Marks the cycle the result bus first shows freshly loaded holding registers
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_loaded <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      hold_loaded <= !accumulate_enable;
      result_valid <= hold_loaded;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      result_is_unsigned <= 1'b0;
      decimation_factor <= '0;
      odd_symmetry <= 1'b0;
      reversal_disable <= 1'b0;
    end else begin
      result_is_unsigned <= fmt_unsigned;
      decimation_factor <= cfg_main[MAIN_DECIM_LSB +: MAIN_DECIM_W];
      odd_symmetry <= cfg_odd_sym;
      reversal_disable <= cfg_aux[AUX_REV_DIS_BIT];
    end
  end

endmodule : fac_output_stage

// *** fac_props.sv ***
// Assertion checker on the output stage ports
`timescale 1ns/1ps
module fac_props import fac_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic accumulate_enable,
  input wire logic [1:0] output_select,
  input wire logic [CFG_ADDR_W-1:0] cfg_address,
  input wire logic [CFG_W-1:0] cfg_data,
  input wire logic cfg_write_n,
  input wire logic [RES_W-1:0] result_bus,
  input wire logic result_valid,
  input wire logic result_is_unsigned,
  input wire logic [MAIN_DECIM_W-1:0] decimation_factor,
  input wire logic odd_symmetry,
  input wire logic reversal_disable
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire wr_main = !cfg_write_n && cfg_address == ADDR_CFG_MAIN;
  wire wr_aux = !cfg_write_n && cfg_address == ADDR_CFG_AUX;
  reset_clear_a: assert property (disable iff (1'b0) reset |=> result_bus == '0 && !result_valid)
    else $error("outputs not cleared by reset");
  main_write_a: assert property (wr_main |-> ##2 decimation_factor == $past(cfg_data[3:0], 2))
    else $error("main write not applied");
  aux_write_a: assert property (wr_aux |-> ##2 reversal_disable == $past(cfg_data[4], 2))
    else $error("aux write not applied");
  cfg_hold_a: assert property (!wr_main && !wr_aux |-> ##2 $stable({decimation_factor, odd_symmetry, reversal_disable}))
    else $error("configuration changed without write");
  result_freeze_a: assert property (cfg_write_n ##1 accumulate_enable && cfg_write_n ##1 $stable(output_select)
    |=> $stable(result_bus))
    else $error("result moved while holding");
  valid_track_a: assert property (!reset ##1 !reset ##1 !reset |-> result_valid == !$past(accumulate_enable, 2))
    else $error("valid does not follow loads");
  odd_signed_a: assert property (odd_symmetry ##1 odd_symmetry |-> !result_is_unsigned)
    else $error("odd symmetry gave unsigned result");
  valid_start_a: assert property ($fell(reset) |-> !result_valid ##1 !result_valid)
    else $error("valid high right after reset");
endmodule : fac_props
bind fac_output_stage fac_props u_props (.clock, .reset, .accumulate_enable, .output_select, .cfg_address, .cfg_data,
  .cfg_write_n, .result_bus, .result_valid, .result_is_unsigned, .decimation_factor, .odd_symmetry, .reversal_disable);

// *** fac_ctrl.sv ***
// Controller model driving the configuration write port
`timescale 1ns/1ps
module fac_ctrl (
  input wire logic clock,
  output logic [fac_pkg::CFG_ADDR_W-1:0] cfg_address,
  output logic [fac_pkg::CFG_W-1:0] cfg_data,
  output logic cfg_write_n
);
  initial begin
    cfg_write_n = 1'h1;
    cfg_address = 9'h1fe;
    cfg_data = 10'h3ff;
  end
  task automatic cfg_write(input logic [fac_pkg::CFG_ADDR_W-1:0] addr, input logic [fac_pkg::CFG_W-1:0] data);
    @(negedge clock);
    cfg_address = addr;
    cfg_data = data;
    cfg_write_n = 1'h0;
    @(negedge clock);
    cfg_write_n = 1'h1;
    // Released lines show garbage, not the last value
    cfg_address = ~addr;
    cfg_data = ~data;
  endtask : cfg_write
endmodule : fac_ctrl

// *** fac_output_stage_tb_top.sv ***
// Self-checking testbench for the FIR output stage
`timescale 1ns/1ps
module fac_output_stage_tb_top;
  import fac_pkg::*;
  typedef struct packed {
    logic [CFG_W-1:0] main, aux;
    logic [1:0] sel;
    logic [PROD_W-1:0] a, b;
    logic [RES_W-1:0] res;
    logic uns;
  } fac_row_t;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic accumulate_enable = 1'h0;
  logic [1:0] output_select = 2'h0;
  logic [TAPS-1:0][PROD_W-1:0] product_a = '0, product_b = '0;
  logic [CFG_ADDR_W-1:0] cfg_address;
  logic [CFG_W-1:0] cfg_data;
  logic cfg_write_n, result_valid, result_is_unsigned, odd_symmetry, reversal_disable;
  logic [RES_W-1:0] result_bus;
  logic [MAIN_DECIM_W-1:0] decimation_factor;
  int fail_count = 0, num_checks = 0, cycles = 0;
  fac_row_t rows[12] = '{
    '{10'h1d0, 10'h010, 2'h2, 22'h123, 22'h40000, 28'h123, 1'h1},
    '{10'h1d0, 10'h010, 2'h3, 22'h123, 22'h40000, 28'h40000, 1'h1},
    '{10'h1d0, 10'h010, 2'h1, 22'h123, 22'h40000, 28'h40123, 1'h1},
    '{10'h1d0, 10'h010, 2'h0, 22'h123, 22'h40000, 28'h223, 1'h1},
    '{10'h110, 10'h039, 2'h2, 22'h123, 22'h40000, 28'h20123, 1'h1},
    '{10'h110, 10'h030, 2'h2, 22'h123, 22'h40000, 28'h223, 1'h1},
    '{10'h110, 10'h03f, 2'h2, 22'h123, 22'h40000, 28'h80123, 1'h1},
    '{10'h1d0, 10'h010, 2'h0, 22'h3fffff, 22'h3ffc00, 28'h400ffe, 1'h1},
    '{10'h1d0, 10'h050, 2'h0, 22'h3fffff, 22'h3ffc00, 28'hffffffe, 1'h0},
    '{10'h135, 10'h000, 2'h1, 22'h123, 22'h40000, 28'h40123, 1'h0},
    '{10'h155, 10'h000, 2'h2, 22'h123, 22'h40000, 28'h123, 1'h1},
    '{10'h195, 10'h000, 2'h3, 22'h123, 22'h40000, 28'h40000, 1'h1}};
  fac_output_stage uut (.clock, .reset, .accumulate_enable, .output_select, .product_a, .product_b, .cfg_address,
    .cfg_data, .cfg_write_n, .result_bus, .result_valid, .result_is_unsigned, .decimation_factor, .odd_symmetry,
    .reversal_disable);
  fac_ctrl ctrl (.clock, .cfg_address, .cfg_data, .cfg_write_n);
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic check(input string name, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(negedge clock);
    check("reset_result", result_bus, '0);
    check("reset_valid", result_valid, '0);
    reset = 1'h0;
    foreach (rows[i]) begin
      ctrl.cfg_write(ADDR_CFG_MAIN, rows[i].main);
      ctrl.cfg_write(ADDR_CFG_AUX, rows[i].aux);
      output_select = rows[i].sel;
      product_a[0] = rows[i].a;
      product_b[0] = rows[i].b;
      repeat (4) @(negedge clock);
      check("result", result_bus, rows[i].res);
      check("unsigned", result_is_unsigned, rows[i].uns);
      check("decimation", decimation_factor, rows[i].main[3:0]);
      check("reversal", reversal_disable, rows[i].aux[4]);
      check("odd_symmetry", odd_symmetry, rows[i].main[5]);
      check("valid", result_valid, 1'h1);
    end
    ctrl.cfg_write(ADDR_CFG_MAIN, 10'h1d0);
    ctrl.cfg_write(ADDR_CFG_AUX, 10'h010);
    ctrl.cfg_write(9'h002, 10'h3ef);
    product_a = {22'h4, 22'h3, 22'h2, 22'h1};
    output_select = FAC_SEL_CELL_A;
    repeat (4) @(negedge clock);
    check("tap_sum", result_bus, 28'ha);
    check("unmapped_aux", reversal_disable, 1'h1);
    check("unmapped_main", decimation_factor, 4'h0);
    accumulate_enable = 1'h1;
    repeat (3) @(negedge clock);
    check("frozen", result_bus, 28'ha);
    check("valid_held", result_valid, 1'h0);
    accumulate_enable = 1'h0;
    repeat (2) @(negedge clock);
    check("accumulated", result_bus, 28'h28);
    @(negedge clock);
    check("restart", result_bus, 28'ha);
    stop_test();
  end
endmodule : fac_output_stage_tb_top
